// File: irq_halt_ctrl.sv
// irq_halt_ctrl: factor flags, masks, vector forming and halt control
// assumes the core, timers and serial unit run on clock; input pins are
// asynchronous and software reaches the registers over APB
//
// Summary of operation
// - request reaches core only with global enable and its mask set
// - accepting an interrupt clears the global enable flag
// - halt stops core clock; an enabled request restarts it
// - halted core with no wake is restarted by watchdog reset
// - two input and six internal sources, each maskable
// - vector in page 1; steps 01h to 0fh by active groups
// - vector bits: 3 stopwatch, 2 clock timer, 1 input, 0 serial
// - entry starts only after the current instruction ends
// - push return address then load vector, twelve cycles total
// - factor flags are read only and clear when read
// - reset clears every factor flag
// - clock timer flags set on 2, 8, 32 hz falling edges
// - stopwatch flags set on 1 hz and 10 hz falling edges
// - serial flag set when an 8-bit transfer completes
// - input flags set on either edge of their pins
// - masks are read/write, one enables, reset to zero
// - timer, stopwatch and serial masks gate their own requests
// - each input pin has a mask feeding its group flag
// - masked input pin never sets its group flag
// - timer, stopwatch, serial flags set whatever their masks
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps

module irq_halt_ctrl
    import irq_halt_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // event sources
    input  wire timebase_t         timebase,
    input  wire logic              serial_done,
    input  wire logic [3:0]        input_group0_pins,
    input  wire logic              input_group1_pin,
    // watchdog
    input  wire logic              wdt_enable,
    input  wire logic              wdt_timeout,
    // cpu core
    input  wire core_req_t         core_req,
    output core_ans_t              core_ans
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    function automatic logic [3:0] clr_bits(input logic [3:0] flags,
                                            input logic [3:0] taken,
                                            input logic [3:0] sets);
        return (flags & ~taken) | sets;
    endfunction

    // ------------------------------------------------------------------
    // input pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [4:0] pin_last_reg;
    logic [4:0] pin_edge;

    // two flops on every pin, a third for edge compare
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            pin_last_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {input_group1_pin, input_group0_pins};
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    assign pin_edge = pin_sync_reg ^ pin_last_reg;

    // ------------------------------------------------------------------
    // time base edge detection
    // ------------------------------------------------------------------
    timebase_t tb_last_reg;

    // previous level of each time base signal
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tb_last_reg <= '0;
        end else begin
            tb_last_reg <= timebase;
        end
    end

    // ------------------------------------------------------------------
    // mask registers and global enable
    // ------------------------------------------------------------------
    logic [3:0] pin_mask0_reg;
    logic       pin_mask1_reg;
    logic [1:0] sw_mask_reg;
    logic [2:0] ct_mask_reg;
    logic       sio_mask_reg;
    logic       gie_reg;
    logic       wr_done;
    logic       rd_done;
    logic [9:0] idx;
    logic       accept;

    assign idx     = paddr[ADDR_W-1:2];
    assign wr_done = psel & penable & pready & pwrite;
    assign rd_done = psel & penable & pready & ~pwrite;

    // mask writes; all masks clear on reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_mask0_reg <= WORD_ZERO[3:0];
            pin_mask1_reg <= 1'b0;
            sw_mask_reg   <= WORD_ZERO[1:0];
            ct_mask_reg   <= WORD_ZERO[2:0];
            sio_mask_reg  <= 1'b0;
        end else if (wr_done) begin
            case (idx)
                IDX_PIN_MASK0: pin_mask0_reg <= pwdata[3:0];
                IDX_PIN_MASK1: pin_mask1_reg <= pwdata[BIT_GROUP1_MASK];
                IDX_SW_MASK:   sw_mask_reg   <= pwdata[1:0];
                IDX_CT_MASK:   ct_mask_reg   <= pwdata[2:0];
                IDX_SIO_MASK:  sio_mask_reg  <= pwdata[BIT_SIO];
                default: ;
            endcase
        end
    end

    // global enable: cleared on acceptance, set or cleared by the core
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg <= 1'b0;
        end else if (accept) begin
            gie_reg <= 1'b0;
        end else if (core_req.gie_set) begin
            gie_reg <= 1'b1;
        end else if (core_req.gie_clr) begin
            gie_reg <= 1'b0;
        end else if (wr_done && idx == IDX_CORE_CTRL) begin
            gie_reg <= pwdata[BIT_GIE];
        end
    end

    // ------------------------------------------------------------------
    // factor flags
    // ------------------------------------------------------------------
    logic [3:0] ct_flag_reg;    // 2hz, 8hz, 32hz in bits 2..0
    logic [3:0] swin_flag_reg;  // group1, group0, 1hz, 10hz
    logic [3:0] sio_flag_reg;
    logic [3:0] ct_set;
    logic [3:0] swin_set;
    logic [3:0] sio_set;
    logic [3:0] ct_taken;
    logic [3:0] swin_taken;
    logic [3:0] sio_taken;
    logic [3:0] rd_word_reg;

    // set terms, unaffected by the timer and serial masks
    always_comb begin
        ct_set                 = WORD_ZERO;
        ct_set[BIT_CT_2HZ]     = fell(tb_last_reg.ct_2hz,
                                      timebase.ct_2hz);
        ct_set[BIT_CT_8HZ]     = fell(tb_last_reg.ct_8hz,
                                      timebase.ct_8hz);
        ct_set[BIT_CT_32HZ]    = fell(tb_last_reg.ct_32hz,
                                      timebase.ct_32hz);
        swin_set               = WORD_ZERO;
        swin_set[BIT_SW_1HZ]   = fell(tb_last_reg.sw_1hz,
                                      timebase.sw_1hz);
        swin_set[BIT_SW_10HZ]  = fell(tb_last_reg.sw_10hz,
                                      timebase.sw_10hz);
        swin_set[BIT_IN_GROUP0] = |(pin_edge[3:0] & pin_mask0_reg);
        swin_set[BIT_IN_GROUP1] = pin_edge[4] & pin_mask1_reg;
        sio_set                = WORD_ZERO;
        sio_set[BIT_SIO]       = serial_done;
    end

    // a read clears only the bits it actually returned as set
    assign ct_taken   = (rd_done && idx == IDX_CT_FLAG)    ? rd_word_reg
                                                           : WORD_ZERO;
    assign swin_taken = (rd_done && idx == IDX_SW_IN_FLAG) ? rd_word_reg
                                                           : WORD_ZERO;
    assign sio_taken  = (rd_done && idx == IDX_SIO_FLAG)   ? rd_word_reg
                                                           : WORD_ZERO;

    // flag update, new events win over the clearing read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ct_flag_reg   <= WORD_ZERO;
            swin_flag_reg <= WORD_ZERO;
            sio_flag_reg  <= WORD_ZERO;
        end else begin
            ct_flag_reg   <= clr_bits(ct_flag_reg, ct_taken, ct_set);
            swin_flag_reg <= clr_bits(swin_flag_reg, swin_taken,
                                      swin_set);
            sio_flag_reg  <= clr_bits(sio_flag_reg, sio_taken, sio_set);
        end
    end

    // ------------------------------------------------------------------
    // gated requests and vector forming
    // ------------------------------------------------------------------
    logic [3:0] group_req;
    logic       irq_req;

    // one bit per requesting and enabled group
    always_comb begin
        group_req                = WORD_ZERO;
        group_req[VEC_STOPWATCH] = |(swin_flag_reg[1:0] & sw_mask_reg);
        group_req[VEC_CLKTIMER]  = |(ct_flag_reg[2:0] & ct_mask_reg);
        group_req[VEC_INPUTPORT] =
            (swin_flag_reg[BIT_IN_GROUP0] & (|pin_mask0_reg)) |
            (swin_flag_reg[BIT_IN_GROUP1] & pin_mask1_reg);
        group_req[VEC_SERIAL]    = sio_flag_reg[BIT_SIO] & sio_mask_reg;
    end

    assign irq_req = gie_reg & (|group_req);

    // ------------------------------------------------------------------
    // core sequencing: run, halt and interrupt entry
    // ------------------------------------------------------------------
    core_state_t state_reg;
    logic [3:0]  entry_cnt_reg;
    logic        wdt_wake;

    // acceptance at an instruction boundary, or straight from halt
    assign accept   = irq_req &&
                      ((state_reg == ST_RUN && core_req.instr_end) ||
                       state_reg == ST_HALTED);
    assign wdt_wake = state_reg == ST_HALTED && !irq_req &&
                      wdt_enable && wdt_timeout;

    // state transitions
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (accept) begin
                        state_reg <= ST_ENTRY;
                    end else if (core_req.halt_exec) begin
                        state_reg <= ST_HALTED;
                    end
                end
                ST_HALTED: begin
                    if (accept) begin
                        state_reg <= ST_ENTRY;
                    end else if (wdt_wake) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_ENTRY: begin
                    if (entry_cnt_reg == ENTRY_LAST) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // entry cycle counter, twelve cycles for push and vector load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            entry_cnt_reg <= WORD_ZERO;
        end else if (state_reg == ST_ENTRY) begin
            entry_cnt_reg <= entry_cnt_reg + 4'h1;
        end else begin
            entry_cnt_reg <= WORD_ZERO;
        end
    end

    // core-facing outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_ans <= '0;
            core_ans.cpu_clk_en <= 1'b1;
        end else begin
            core_ans.cpu_clk_en  <= !(state_reg == ST_RUN &&
                                      core_req.halt_exec && !accept) &&
                                    !(state_reg == ST_HALTED &&
                                      !accept && !wdt_wake);
            core_ans.entry_busy  <= accept ||
                                    (state_reg == ST_ENTRY &&
                                     entry_cnt_reg != ENTRY_LAST);
            core_ans.vector_load <= state_reg == ST_ENTRY &&
                                    entry_cnt_reg == ENTRY_LAST;
            core_ans.core_reset  <= wdt_wake;
            if (accept) begin
                core_ans.vector_low <= group_req;
            end
        end
    end

    // ------------------------------------------------------------------
    // apb read path and handshake
    // ------------------------------------------------------------------
    logic [3:0] rd_word;
    logic       rd_hit;

    // read multiplexer; unused bits read as zero
    always_comb begin
        rd_word = WORD_ZERO;
        rd_hit  = 1'b1;
        case (idx)
            IDX_PIN_MASK0:  rd_word = pin_mask0_reg;
            IDX_PIN_MASK1:  rd_word[BIT_GROUP1_MASK] = pin_mask1_reg;
            IDX_SW_MASK:    rd_word[1:0] = sw_mask_reg;
            IDX_CT_MASK:    rd_word[2:0] = ct_mask_reg;
            IDX_SIO_MASK:   rd_word[BIT_SIO] = sio_mask_reg;
            IDX_CT_FLAG:    rd_word = ct_flag_reg;
            IDX_SW_IN_FLAG: rd_word = swin_flag_reg;
            IDX_SIO_FLAG:   rd_word = sio_flag_reg;
            IDX_CORE_CTRL: begin
                rd_word[BIT_GIE]    = gie_reg;
                rd_word[BIT_HALTED] = state_reg == ST_HALTED;
            end
            default:        rd_hit = 1'b0;
        endcase
    end

    // data sampled in the setup cycle, answered in the access cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= RDATA_ZERO;
            rd_word_reg <= WORD_ZERO;
        end else if (psel && !penable) begin
            pready      <= 1'b1;
            pslverr     <= !rd_hit;
            prdata      <= pwrite ? RDATA_ZERO : {28'h0000000, rd_word};
            rd_word_reg <= pwrite ? WORD_ZERO : rd_word;
        end else begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end
    end

endmodule // irq_halt_ctrl

// File: irq_halt_pkg.sv
// irq_halt_pkg: constants and types for the interrupt and halt block
// assumes a 4-bit register word carried in the low bits of a 32-bit APB bus
package irq_halt_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          IDX_W           = 10;
    localparam logic [9:0]  IDX_PIN_MASK0   = 10'h2e5;
    localparam logic [9:0]  IDX_SW_MASK     = 10'h2e6;
    localparam logic [9:0]  IDX_PIN_MASK1   = 10'h2e7;
    localparam logic [9:0]  IDX_CT_MASK     = 10'h2e8;
    localparam logic [9:0]  IDX_CT_FLAG     = 10'h2e9;
    localparam logic [9:0]  IDX_SW_IN_FLAG  = 10'h2ea;
    localparam logic [9:0]  IDX_SIO_MASK    = 10'h2f2;
    localparam logic [9:0]  IDX_SIO_FLAG    = 10'h2f3;
    localparam logic [9:0]  IDX_CORE_CTRL   = 10'h300;

    // ------------------------------------------------------------------
    // field positions within the 4-bit words
    // ------------------------------------------------------------------
    localparam int          BIT_CT_32HZ     = 0;
    localparam int          BIT_CT_8HZ      = 1;
    localparam int          BIT_CT_2HZ      = 2;
    localparam int          BIT_SW_10HZ     = 0;
    localparam int          BIT_SW_1HZ      = 1;
    localparam int          BIT_IN_GROUP0   = 2;
    localparam int          BIT_IN_GROUP1   = 3;
    localparam int          BIT_SIO         = 0;
    localparam int          BIT_GROUP1_MASK = 2;
    localparam int          BIT_GIE         = 0;
    localparam int          BIT_HALTED      = 1;

    // vector bit positions in the low program-counter nibble
    localparam int          VEC_SERIAL      = 0;
    localparam int          VEC_INPUTPORT   = 1;
    localparam int          VEC_CLKTIMER    = 2;
    localparam int          VEC_STOPWATCH   = 3;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [3:0]  WORD_ZERO       = 4'h0;
    localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
    localparam int          ENTRY_CYCLES    = 12;
    localparam logic [3:0]  ENTRY_LAST      = 4'(ENTRY_CYCLES - 1);

    // time base signals from the clock timer and stopwatch
    typedef struct packed {
        logic ct_2hz;
        logic ct_8hz;
        logic ct_32hz;
        logic sw_1hz;
        logic sw_10hz;
    } timebase_t;

    // requests from the cpu core
    typedef struct packed {
        logic halt_exec;    // halt instruction executed (pulse)
        logic instr_end;    // current instruction finishes (pulse)
        logic gie_set;      // enable instruction (pulse)
        logic gie_clr;      // disable instruction (pulse)
    } core_req_t;

    // answers to the cpu core
    typedef struct packed {
        logic       cpu_clk_en;   // core clock runs
        logic       entry_busy;   // stack push and vector load under way
        logic       vector_load;  // load vector into pc (pulse)
        logic       core_reset;   // watchdog restart from halt (pulse)
        logic [3:0] vector_low;   // low pc nibble, page 1
    } core_ans_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALTED,
        ST_ENTRY
    } core_state_t;

endpackage

// File: irq_halt_sva.sv
// irq_halt_sva: port checker for the interrupt and halt block
// assumes a bind onto irq_halt_ctrl, one clock domain
`timescale 1ns/10ps

module irq_halt_sva
    import irq_halt_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wdt_enable,
    input wire logic        wdt_timeout,
    input wire core_req_t   core_req,
    input wire core_ans_t   core_ans
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // entry: twelve busy cycles, then the vector load alone
    sequence entry_run;
        core_ans.entry_busy[*8] ##1 core_ans.entry_busy[*4];
    endsequence
    sequence entry_done;
        !core_ans.entry_busy && core_ans.vector_load;
    endsequence

    AST_ENTRY_LEN: assert property (
        $rose(core_ans.entry_busy) |-> entry_run ##1 entry_done)
        else $error("entry length wrong");
    AST_VEC_STEP: assert property (
        $rose(core_ans.entry_busy) |-> core_ans.vector_low != 4'h0)
        else $error("vector step zero");
    AST_ENTRY_CAUSE: assert property (
        $rose(core_ans.entry_busy) |->
            $past(core_req.instr_end) || !$past(core_ans.cpu_clk_en))
        else $error("entry without instruction end");
    AST_VEC_HOLD: assert property (
        !$rose(core_ans.entry_busy) |-> $stable(core_ans.vector_low))
        else $error("vector changed outside accept");
    AST_HALT_STOP: assert property (
        core_req.halt_exec && core_ans.cpu_clk_en && !core_req.instr_end
            && !core_ans.entry_busy |=> !core_ans.cpu_clk_en)
        else $error("halt did not stop clock");
    AST_WAKE: assert property (
        $rose(core_ans.cpu_clk_en) |->
            core_ans.entry_busy || core_ans.core_reset)
        else $error("clock restart without cause");
    AST_WDT: assert property (
        core_ans.core_reset |-> $past(wdt_timeout) && $past(wdt_enable)
            && !$past(core_ans.cpu_clk_en))
        else $error("core reset without watchdog");
    AST_PREADY: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    AST_ERR_ZERO: assert property (
        pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
endmodule // irq_halt_sva

bind irq_halt_ctrl irq_halt_sva i_irq_halt_sva (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout),
    .core_req(core_req), .core_ans(core_ans));

// File: core_model.sv
// core_model: behavioural cpu core giving instruction ends and halts
// assumes the bench pulses halt_cmd for one clock
`timescale 1ns/10ps

module core_model
    import irq_halt_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      halt_cmd,
    input  wire logic      slow,
    input  wire core_ans_t core_ans,
    output core_req_t      core_req = '0
);
    logic [2:0] step_reg = 3'h0;

    // instructions end every two or eight clocks while running
    always @(posedge clock) begin
        step_reg <= step_reg + 3'h1;
        core_req.instr_end <= core_ans.cpu_clk_en && !core_ans.entry_busy
            && !halt_cmd && (slow ? step_reg == 3'h7 : step_reg[0]);
        core_req.halt_exec <= halt_cmd && !core_ans.entry_busy;
        core_req.gie_set <= halt_cmd; // enable in the same cycle as halt
        core_req.gie_clr <= 1'b0;
    end
endmodule // core_model

// File: test_vectored_interrupt_halt_logic.sv
// test_vectored_interrupt_halt_logic: self-checking bench
// assumes core_model as the core, apb master tasks, 25 MHz clock
`timescale 1ns/10ps

module test_vectored_interrupt_halt_logic
    import irq_halt_pkg::*;
;
    logic        clock = 1'b0, nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, last_err;
    timebase_t   timebase = '0;
    logic        serial_done = 1'b0, pin1 = 1'b0, halt_cmd = 1'b0;
    logic [3:0]  pins0 = 4'h0;
    logic        wdt_enable = 1'b0, wdt_timeout = 1'b0, slow = 1'b0;
    core_req_t   core_req;
    core_ans_t   core_ans;
    int          mismatches = 0, cmp_count = 0, cycles = 0, n;

    irq_halt_ctrl i_irq_halt_ctrl (.clock(clock), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timebase(timebase), .serial_done(serial_done),
        .input_group0_pins(pins0), .input_group1_pin(pin1),
        .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout),
        .core_req(core_req), .core_ans(core_ans));
    core_model i_core_model (.clock(clock), .halt_cmd(halt_cmd),
        .slow(slow), .core_ans(core_ans), .core_req(core_req));

    // clock and hang guard
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [3:0] wd, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {28'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [3:0] d);
        logic [31:0] r;
        apb(1'b1, idx, d, r);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, idx, 4'h0, r);
        check(r, e);
    endtask

    // falling edges on chosen time bases, serial pulse, new pin levels
    task automatic events(input logic [4:0] tb, input logic sd,
                          input logic [4:0] p);
        timebase <= tb;
        {pin1, pins0} <= p;
        @(posedge clock);
        timebase <= '0;
        serial_done <= sd;
        @(posedge clock);
        serial_done <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // wait for entry, then count its busy cycles into n
    task automatic wait_entry;
        n = 0;
        while (core_ans.entry_busy !== 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        while (core_ans.entry_busy === 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
    endtask

    task automatic t_regs;
        logic [9:0] ix [5] = '{IDX_PIN_MASK0, IDX_SW_MASK, IDX_PIN_MASK1,
                               IDX_CT_MASK, IDX_SIO_MASK};
        logic [3:0] wv [5] = '{4'hf, 4'h3, 4'h4, 4'h7, 4'h1};
        foreach (ix[i]) rd_chk(ix[i], 32'h0);
        rd_chk(IDX_CT_FLAG, 32'h0);
        rd_chk(IDX_SW_IN_FLAG, 32'h0);
        rd_chk(IDX_SIO_FLAG, 32'h0);
        foreach (ix[i]) begin
            wr(ix[i], 4'hf);
            rd_chk(ix[i], {28'h0, wv[i]});
            wr(ix[i], 4'h0);
        end
        wr(IDX_CT_FLAG, 4'hf);
        rd_chk(IDX_CT_FLAG, 32'h0);
        rd_chk(10'h3ff, 32'h0);
        check(last_err, 1'b1);
    endtask

    task automatic t_flags;
        logic [4:0] tv [3] = '{5'h11, 5'h0a, 5'h04};
        logic [3:0] cv [3] = '{4'h4, 4'h2, 4'h1};
        logic [3:0] sv [3] = '{4'h1, 4'h2, 4'h0};
        events(5'h1f, 1'b1, 5'h1f);
        rd_chk(IDX_CT_FLAG, 32'h7);
        rd_chk(IDX_SW_IN_FLAG, 32'h3);
        rd_chk(IDX_SIO_FLAG, 32'h1);
        rd_chk(IDX_SW_IN_FLAG, 32'h0);
        foreach (tv[i]) begin
            events(tv[i], 1'b0, 5'h1f);
            rd_chk(IDX_CT_FLAG, {28'h0, cv[i]});
            rd_chk(IDX_SW_IN_FLAG, {28'h0, sv[i]});
        end
        wr(IDX_PIN_MASK0, 4'h1);
        wr(IDX_PIN_MASK1, 4'h4);
        events(5'h00, 1'b0, 5'h0e);
        rd_chk(IDX_SW_IN_FLAG, 32'hc);
        events(5'h00, 1'b0, 5'h00);
        rd_chk(IDX_SW_IN_FLAG, 32'h0);
    endtask

    task automatic t_irq;
        wr(IDX_CT_MASK, 4'h4);
        wr(IDX_SW_MASK, 4'h2);
        wr(IDX_SIO_MASK, 4'h1);
        events(5'h12, 1'b0, 5'h00);
        check(core_ans.entry_busy, 1'b0);
        wr(IDX_CORE_CTRL, 4'h1);
        wait_entry;
        check(n, 12);
        check(core_ans.vector_low, 4'hc);
        rd_chk(IDX_CORE_CTRL, 32'h0);
        rd_chk(IDX_CT_FLAG, 32'h4);
        rd_chk(IDX_SW_IN_FLAG, 32'h2);
    endtask

    task automatic t_halt;
        slow <= 1'b1;
        halt_cmd <= 1'b1;
        @(posedge clock);
        halt_cmd <= 1'b0;
        repeat (3) @(posedge clock);
        check(core_ans.cpu_clk_en, 1'b0);
        rd_chk(IDX_CORE_CTRL, 32'h3);
        serial_done <= 1'b1;
        @(posedge clock);
        serial_done <= 1'b0;
        wait_entry;
        check(n, 12);
        check(core_ans.vector_low, 4'h1);
        rd_chk(IDX_SIO_FLAG, 32'h1);
        halt_cmd <= 1'b1;
        wdt_enable <= 1'b1;
        @(posedge clock);
        halt_cmd <= 1'b0;
        repeat (3) @(posedge clock);
        wdt_timeout <= 1'b1;
        @(posedge clock);
        wdt_timeout <= 1'b0;
        @(posedge clock);
        check(core_ans.core_reset, 1'b1);
        check(core_ans.vector_low, 4'h1);
    endtask

    // reset, then the scenarios in order
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs;
        t_flags;
        t_irq;
        t_halt;
        complete_run;
    end
endmodule // test_vectored_interrupt_halt_logic
